// File: core/cxr_defines.svh
// offsets, field positions and constants of the extraction rewriter
`ifndef CXR_DEFINES_SVH
`define CXR_DEFINES_SVH

`define CXR_NUM_QUEUES 8
`define CXR_HDR_LAST 4'hF
`define CXR_MAC_LAST 4'hB
`define CXR_CNT_RESET 4'h0
`define CXR_POP_NONE 8'h00
`define CXR_POP_ONE 8'h01
`define CXR_QIDX_RESET 3'h7

`define CXR_SWAP_CMD 4'h8
`define CXR_MCAST_BIT 40
`define CXR_PTP2_CMD 3'h3

`define CXR_LEN_BIAS 15'h0050
`define CXR_LEN_UNIT 15'h003C

`define CXR_RSV_TOP_BIT 127
`define CXR_RWC_LSB 117
`define CXR_RXT_LSB 85
`define CXR_LREM_LSB 79
`define CXR_LWRD_LSB 71
`define CXR_RSV_MID_LSB 47
`define CXR_SRCP_LSB 43
`define CXR_RULE_LSB 37
`define CXR_RSV_LOW_BIT 36
`define CXR_SMPL_LSB 32
`define CXR_HIT_BIT 31
`define CXR_DROP_BIT 30
`define CXR_LRN_LSB 28
`define CXR_QMASK_LSB 20
`define CXR_CLASS_LSB 17
`define CXR_TAG_BIT 16
`define CXR_PCP_LSB 13
`define CXR_DEI_BIT 12
`define CXR_VID_LSB 0

`endif

// File: core/cxr_pkg.sv
// types shared by the extraction rewriter files
package cxr_pkg;
    typedef logic [7:0] cxr_byte_t;
    typedef logic [7:0] cxr_qmask_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WAIT = 6'h02,
        ST_HDR = 6'h04,
        ST_CAP = 6'h08,
        ST_MAC = 6'h10,
        ST_PASS = 6'h20
    } cxr_state_t;
endpackage : cxr_pkg

// File: core/cxr_fifo.sv
// small fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module cxr_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    import cxr_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic [WIDTH-1:0] rd_data_reg;
    logic rd_valid_reg;
    logic push;
    logic load;

    assign wr_ready = ce && (cnt_reg != (AW+1)'(DEPTH));
    assign push = wr_valid && wr_ready;
    assign load = ce && (cnt_reg != '0) && (!rd_valid_reg || rd_ready);
    assign rd_valid = rd_valid_reg && ce;
    assign rd_data = rd_data_reg;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp_reg] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (load) begin
                rp_reg <= rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
        end else if (load) begin
            rd_valid_reg <= 1'b1;
            rd_data_reg <= mem[rp_reg];
        end else if (ce && rd_ready) begin
            rd_valid_reg <= 1'b0;
        end
    end
endmodule : cxr_fifo
`default_nettype wire

// File: core/cxr_top.sv
// cpu extraction scheduler and header rewriter
`timescale 1ns/1ps
`default_nettype none
`include "cxr_defines.svh"

// Summary of operation
// - lookup command 8 swaps the MACs
// - swapped source MAC gets bit 40 cleared
// - replace flag loads per-port source MAC
// - eight queues mapped to ports 11, 12
// - strict mode serves highest non-empty queue
// - round robin serves mapped queues in turn
// - header enable prepends extraction header
// - 9-bit rewrite command at bit 117
// - receive time 32 bits at bit 85
// - length remainder and words encode length
// - ingress port 4 bits at bit 43
// - rule identifier 6 bits at 37
// - sampling identifier 4 bits at 32
// - bit 31 set on copy actions
// - bit 30 carries drop level
// - learning action 2 bits at 28
// - queue hit mask 8 bits at 20
// - service class 3 bits at 17
// - bit 16 gives tag kind
// - pcp, dei and vid at 13, 12, 0
module cxr_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire cxr_pkg::cxr_qmask_t queue_nonempty,
    input wire cxr_pkg::cxr_qmask_t queue_port_map,
    input wire logic [1:0] round_robin_enable,
    input wire logic [1:0] header_insert_enable,
    output cxr_pkg::cxr_qmask_t queue_pop,
    input wire logic in_valid,
    output logic in_ready,
    input wire cxr_pkg::cxr_byte_t in_data,
    input wire logic in_sof,
    input wire logic in_eof,
    input wire logic [8:0] rewrite_command,
    input wire logic [31:0] receive_time_value,
    input wire logic [13:0] frame_length,
    input wire logic [3:0] ingress_port_number,
    input wire logic [5:0] rule_identifier,
    input wire logic [3:0] sampling_identifier,
    input wire logic copy_to_host_action,
    input wire logic single_hit_copy_action,
    input wire logic drop_level,
    input wire logic [1:0] learning_action,
    input wire cxr_pkg::cxr_qmask_t queue_hit_mask,
    input wire logic [2:0] service_class,
    input wire logic tag_kind,
    input wire logic [2:0] pcp,
    input wire logic dei,
    input wire logic [11:0] vid,
    input wire logic [3:0] lookup_rewrite_command,
    input wire logic source_address_replace_enable,
    input wire logic [47:0] egress_source_address_low,
    input wire logic [47:0] egress_source_address_high,
    output logic out_valid,
    input wire logic out_ready,
    output cxr_pkg::cxr_byte_t out_data,
    output logic out_sof,
    output logic out_eof,
    output logic out_port,
    output logic busy
);
    import cxr_pkg::*;

    // pick a queue: strict takes the highest, round robin the next after last
    function automatic logic [3:0] pick_queue(
        input logic [7:0] elig,
        input logic rr,
        input logic [2:0] last
    );
        logic [3:0] res;
        logic [2:0] j;
        res = 4'h0;
        if (!rr) begin
            for (int i = 0; i < `CXR_NUM_QUEUES; i++) begin
                if (elig[i]) begin
                    res = {1'b1, 3'(i)};
                end
            end
        end else begin
            for (int k = `CXR_NUM_QUEUES; k >= 1; k--) begin
                j = last + 3'(k);
                if (elig[j]) begin
                    res = {1'b1, j};
                end
            end
        end
        return res;
    endfunction : pick_queue

    // new address pair after swap or source replacement
    function automatic logic [95:0] fix_mac(
        input logic [95:0] raw,
        input logic swap,
        input logic repl,
        input logic [47:0] addr
    );
        logic [95:0] res;
        res = raw;
        if (swap) begin
            res = {raw[47:0], raw[95:48]};
            res[`CXR_MCAST_BIT] = 1'b0;
        end else if (repl) begin
            res[47:0] = addr;
        end
        return res;
    endfunction : fix_mac

    cxr_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [127:0] hdr_reg;
    logic [127:0] hdr_next;
    logic [95:0] cap_reg;
    logic [95:0] mac_reg;
    logic [95:0] cap_next;
    logic swap_reg;
    logic repl_reg;
    logic port_reg;
    logic hdr_used_reg;
    logic eof_seen_reg;
    logic [2:0] last0_reg;
    logic [2:0] last1_reg;
    logic turn_reg;
    logic [7:0] elig0;
    logic [7:0] elig1;
    logic [3:0] pick0;
    logic [3:0] pick1;
    logic grant_port;
    logic [2:0] grant_q;
    logic start;
    logic [14:0] len_biased;
    logic push_valid;
    logic push_ready;
    logic push_sof;
    logic push_eof;
    cxr_byte_t push_byte;
    logic push_fire;
    logic in_fire;
    logic [47:0] port_addr;

    // queue scheduling per cpu port, ports alternate when both have work
    assign elig0 = queue_nonempty & ~queue_port_map;
    assign elig1 = queue_nonempty & queue_port_map;
    assign pick0 = pick_queue(elig0, round_robin_enable[0], last0_reg);
    assign pick1 = pick_queue(elig1, round_robin_enable[1], last1_reg);
    assign grant_port = (pick0[3] && pick1[3]) ? turn_reg : pick1[3];
    assign grant_q = grant_port ? pick1[2:0] : pick0[2:0];
    assign start = ce && (state_reg == ST_IDLE) && (pick0[3] || pick1[3]);
    assign queue_pop = start ? (`CXR_POP_ONE << grant_q) : `CXR_POP_NONE;
    assign busy = (state_reg != ST_IDLE);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            last0_reg <= `CXR_QIDX_RESET;
            last1_reg <= `CXR_QIDX_RESET;
            turn_reg <= 1'b0;
        end else if (start) begin
            turn_reg <= ~grant_port;
            if (grant_port) begin
                last1_reg <= grant_q;
            end else begin
                last0_reg <= grant_q;
            end
        end
    end

    // extraction header assembled from the side-band of the first beat
    assign len_biased = 15'(frame_length) + `CXR_LEN_BIAS;

    always_comb begin
        hdr_next = '0;
        hdr_next[`CXR_RWC_LSB +: 9] = rewrite_command;
        hdr_next[`CXR_RXT_LSB +: 32] = receive_time_value;
        hdr_next[`CXR_LREM_LSB +: 6] = 6'(len_biased % `CXR_LEN_UNIT);
        hdr_next[`CXR_LWRD_LSB +: 8] = 8'(len_biased / `CXR_LEN_UNIT);
        hdr_next[`CXR_SRCP_LSB +: 4] = ingress_port_number;
        hdr_next[`CXR_HIT_BIT] = copy_to_host_action | single_hit_copy_action;
        if (hdr_next[`CXR_HIT_BIT]) begin
            hdr_next[`CXR_RULE_LSB +: 6] = rule_identifier;
        end
        hdr_next[`CXR_SMPL_LSB +: 4] = sampling_identifier;
        hdr_next[`CXR_DROP_BIT] = drop_level;
        hdr_next[`CXR_LRN_LSB +: 2] = learning_action;
        hdr_next[`CXR_QMASK_LSB +: 8] = queue_hit_mask;
        hdr_next[`CXR_CLASS_LSB +: 3] = service_class;
        hdr_next[`CXR_TAG_BIT] = tag_kind;
        hdr_next[`CXR_PCP_LSB +: 3] = pcp;
        hdr_next[`CXR_DEI_BIT] = dei;
        hdr_next[`CXR_VID_LSB +: 12] = vid;
    end

    // byte stream toward the output fifo
    always_comb begin
        push_valid = 1'b0;
        push_byte = in_data;
        push_sof = 1'b0;
        push_eof = 1'b0;
        in_ready = 1'b0;
        unique case (state_reg)
            ST_IDLE, ST_WAIT: begin
            end
            ST_HDR: begin
                push_valid = 1'b1;
                push_byte = hdr_reg[127:120];
                push_sof = (cnt_reg == `CXR_CNT_RESET);
            end
            ST_CAP: begin
                in_ready = ce;
            end
            ST_MAC: begin
                push_valid = 1'b1;
                push_byte = mac_reg[95:88];
                push_sof = (cnt_reg == `CXR_CNT_RESET) && !hdr_used_reg;
                push_eof = eof_seen_reg && (cnt_reg == `CXR_MAC_LAST);
            end
            ST_PASS: begin
                push_valid = in_valid;
                push_eof = in_eof;
                in_ready = push_ready;
            end
        endcase
    end

    assign push_fire = push_valid && push_ready;
    assign in_fire = in_valid && in_ready;
    assign cap_next = {cap_reg[87:0], in_data};
    assign port_addr = {egress_source_address_high[port_reg*24 +: 24], egress_source_address_low[port_reg*24 +: 24]};

    // frame sequencing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= `CXR_CNT_RESET;
        end else if (ce) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (in_valid && in_sof) begin
                        cnt_reg <= `CXR_CNT_RESET;
                        state_reg <= header_insert_enable[port_reg] ? ST_HDR : ST_CAP;
                    end
                end
                ST_HDR: begin
                    if (push_fire) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == `CXR_HDR_LAST) begin
                            cnt_reg <= `CXR_CNT_RESET;
                            state_reg <= ST_CAP;
                        end
                    end
                end
                ST_CAP: begin
                    if (in_fire) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == `CXR_MAC_LAST || in_eof) begin
                            cnt_reg <= `CXR_CNT_RESET;
                            state_reg <= ST_MAC;
                        end
                    end
                end
                ST_MAC: begin
                    if (push_fire) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == `CXR_MAC_LAST) begin
                            cnt_reg <= `CXR_CNT_RESET;
                            state_reg <= eof_seen_reg ? ST_IDLE : ST_PASS;
                        end
                    end
                end
                ST_PASS: begin
                    if (in_fire && in_eof) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // per-frame flags and header capture
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hdr_reg <= '0;
            swap_reg <= 1'b0;
            repl_reg <= 1'b0;
            port_reg <= 1'b0;
            hdr_used_reg <= 1'b0;
        end else if (ce) begin
            if (start) begin
                port_reg <= grant_port;
            end
            if (state_reg == ST_WAIT && in_valid && in_sof) begin
                hdr_reg <= hdr_next;
                hdr_used_reg <= header_insert_enable[port_reg];
                swap_reg <= (lookup_rewrite_command == `CXR_SWAP_CMD);
                repl_reg <= source_address_replace_enable;
            end else if (state_reg == ST_HDR && push_fire) begin
                hdr_reg <= {hdr_reg[119:0], 8'h00};
            end
        end
    end

    // address capture and rewrite
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cap_reg <= '0;
            mac_reg <= '0;
            eof_seen_reg <= 1'b0;
        end else if (ce) begin
            if (state_reg == ST_WAIT) begin
                eof_seen_reg <= 1'b0;
            end
            if (state_reg == ST_CAP && in_fire) begin
                cap_reg <= cap_next;
                eof_seen_reg <= in_eof;
                if (cnt_reg == `CXR_MAC_LAST || in_eof) begin
                    mac_reg <= fix_mac(cap_next, swap_reg, repl_reg, port_addr);
                end
            end else if (state_reg == ST_MAC && push_fire) begin
                mac_reg <= {mac_reg[87:0], 8'h00};
            end
        end
    end

    cxr_fifo #(
        .WIDTH(11),
        .DEPTH(8)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .wr_valid(push_valid),
        .wr_ready(push_ready),
        .wr_data({port_reg, push_sof, push_eof, push_byte}),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .rd_data({out_port, out_sof, out_eof, out_data})
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_hdr_loaded;
        (state_reg == ST_WAIT) && in_valid && in_sof && ce ##1 (state_reg == ST_HDR) || (state_reg == ST_CAP);
    endsequence

    property p_swap;
        (state_reg == ST_MAC) && (cnt_reg == 4'h0) && swap_reg |->
            mac_reg[95:48] == cap_reg[47:0] && mac_reg[47:41] == cap_reg[95:89] && !mac_reg[40];
    endproperty
    a_swap: assert property (p_swap) else $error("address swap wrong");

    property p_replace;
        (state_reg == ST_MAC) && (cnt_reg == 4'h0) && repl_reg && !swap_reg |->
            mac_reg[47:0] == port_addr && mac_reg[95:48] == cap_reg[95:48];
    endproperty
    a_replace: assert property (p_replace) else $error("source replace wrong");

    property p_pop_port;
        start |-> $onehot(queue_pop) && |(queue_pop & (grant_port ? elig1 : elig0)) ##1 port_reg == $past(grant_port);
    endproperty
    a_pop_port: assert property (p_pop_port) else $error("pop not on mapped queue");

    property p_strict;
        start && !round_robin_enable[grant_port] |->
            ((grant_port ? elig1 : elig0) & ~((queue_pop << 1) - 8'h01)) == 8'h00;
    endproperty
    a_strict: assert property (p_strict) else $error("strict order broken");

    property p_rr;
        start && round_robin_enable[grant_port] && $countones(grant_port ? elig1 : elig0) > 1 |->
            grant_q != (grant_port ? last1_reg : last0_reg);
    endproperty
    a_rr: assert property (p_rr) else $error("round robin repeated queue");

    property p_hdr_start;
        (state_reg == ST_WAIT) && in_valid && in_sof && ce && header_insert_enable[port_reg] |=>
            state_reg == ST_HDR && push_sof && !in_ready;
    endproperty
    a_hdr_start: assert property (p_hdr_start) else $error("header not inserted");

    property p_fields;
        s_hdr_loaded |-> (state_reg != ST_HDR) ||
            (hdr_reg[116:85] == $past(receive_time_value) && hdr_reg[125:117] == $past(rewrite_command)
            && hdr_reg[46:43] == $past(ingress_port_number) && hdr_reg[11:0] == $past(vid));
    endproperty
    a_fields: assert property (p_fields) else $error("header field wrong");

    property p_length;
        $rose(state_reg == ST_HDR) |->
            (15'(hdr_reg[78:71]) * `CXR_LEN_UNIT + 15'(hdr_reg[84:79])) == 15'($past(frame_length)) + `CXR_LEN_BIAS;
    endproperty
    a_length: assert property (p_length) else $error("length encoding wrong");

    property p_reserved;
        $rose(state_reg == ST_HDR) |-> !hdr_reg[127] && hdr_reg[70:47] == 24'h00_0000 && !hdr_reg[36];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_msb_first;
        (state_reg == ST_HDR) && push_fire && (cnt_reg == 4'h0) |-> push_byte == hdr_reg[127:120]
            ##1 (state_reg == ST_HDR) && push_byte == $past(hdr_reg[119:112]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("header order wrong");
endmodule : cxr_top
`default_nettype wire

// File: dv/cxr_host_sink.sv
// readout model of the cpu side, takes bytes with random stalls
`timescale 1ns/1ps
`default_nettype none
module cxr_host_sink (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic out_valid,
    output logic out_ready,
    input wire cxr_pkg::cxr_byte_t out_data,
    input wire logic out_sof,
    input wire logic out_eof,
    input wire logic out_port
);
    import cxr_pkg::*;
    cxr_byte_t cap [0:79];
    int len = 0;
    int nframes = 0;
    logic port;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall && ($urandom_range(0, 3) != 0);
        end
    end
    // header bytes are stored first, most significant byte first
    always @(posedge sys_clk) begin
        if (!rst && out_valid && out_ready) begin
            if (out_sof) len = 0;
            if (len < 80) cap[len] = out_data;
            len = len + 1;
            port = out_port;
            if (out_eof) nframes = nframes + 1;
        end
    end
endmodule : cxr_host_sink
`default_nettype wire

// File: dv/cxr_top_test.sv
// self-checking bench of the extraction scheduler and rewriter
`timescale 1ns/1ps
`default_nettype none
`include "cxr_defines.svh"
module cxr_top_test;
    import cxr_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, stall = 1'b0, busy;
    logic in_valid = 1'b0, in_ready, in_sof = 1'b0, in_eof = 1'b0, out_valid, out_ready, out_sof, out_eof, out_port;
    logic copy_to_host_action = 1'b0, single_hit_copy_action = 1'b0, drop_level = 1'b0, tag_kind = 1'b0, dei = 1'b0;
    logic source_address_replace_enable = 1'b0;
    logic [1:0] round_robin_enable = '0, header_insert_enable = '0, learning_action = '0;
    logic [2:0] service_class = '0, pcp = '0;
    logic [3:0] ingress_port_number = '0, sampling_identifier = '0, lookup_rewrite_command = '0;
    logic [5:0] rule_identifier = '0;
    logic [8:0] rewrite_command = '0;
    logic [11:0] vid = '0;
    logic [13:0] frame_length = '0;
    logic [31:0] receive_time_value = '0;
    logic [47:0] egress_source_address_low = '0, egress_source_address_high = '0;
    cxr_qmask_t queue_nonempty = '0, queue_port_map = '0, queue_hit_mask = '0, queue_pop;
    cxr_byte_t in_data = '0, out_data;
    cxr_byte_t fb [0:63];
    int qcnt [0:7] = '{default: 0};
    int last_q [0:1] = '{7, 7};
    int bad_count = 0, samples_checked = 0, cycles = 0;
    int pops = 0, taken = 0, turn = 0;
    cxr_qmask_t pop_seen = '0, ne_seen = '0;
    cxr_top dut (.sys_clk, .rst, .ce, .queue_nonempty, .queue_port_map, .round_robin_enable, .header_insert_enable,
        .queue_pop, .in_valid, .in_ready, .in_data, .in_sof, .in_eof, .rewrite_command, .receive_time_value,
        .frame_length, .ingress_port_number, .rule_identifier, .sampling_identifier, .copy_to_host_action,
        .single_hit_copy_action, .drop_level, .learning_action, .queue_hit_mask, .service_class, .tag_kind, .pcp,
        .dei, .vid, .lookup_rewrite_command, .source_address_replace_enable, .egress_source_address_low,
        .egress_source_address_high, .out_valid, .out_ready, .out_data, .out_sof, .out_eof, .out_port, .busy);
    cxr_host_sink sink (.sys_clk, .rst, .stall, .out_valid, .out_ready, .out_data, .out_sof, .out_eof, .out_port);
    always #25 sys_clk = ~sys_clk;
    task automatic chk(logic [127:0] seen, logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    always @(posedge sys_clk) begin
        cycles++;
        ce <= (cycles < 500) || ($urandom_range(0, 7) != 0);
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    function automatic cxr_qmask_t nonempty_now();
        cxr_qmask_t m;
        for (int i = 0; i < 8; i++) m[i] = (qcnt[i] > 0);
        return m;
    endfunction : nonempty_now
    // queue system side: a pop may come while the previous frame still drains
    always @(negedge sys_clk) begin
        if (queue_pop !== 8'h00) begin
            pop_seen = queue_pop;
            ne_seen = queue_nonempty;
            pops++;
        end
    end
    function automatic int exp_pick(cxr_qmask_t m, logic r, int last);
        for (int k = 1; k <= 8; k++) begin
            int q;
            q = r ? (last + k) % 8 : 8 - k;
            if (m[q]) return q;
        end
        return 0;
    endfunction : exp_pick
    function automatic logic [127:0] exp_hdr();
        logic [14:0] t;
        logic hit;
        t = {1'b0, frame_length} + `CXR_LEN_BIAS;
        hit = copy_to_host_action | single_hit_copy_action;
        return {1'b0, rewrite_command, receive_time_value, 6'(t % `CXR_LEN_UNIT), 8'(t / `CXR_LEN_UNIT), 24'h00_0000,
            ingress_port_number, hit ? rule_identifier : 6'h00, 1'b0, sampling_identifier, hit, drop_level,
            learning_action, queue_hit_mask, service_class, tag_kind, pcp, dei, vid};
    endfunction : exp_hdr
    function automatic cxr_byte_t exp_byte(int i, int mode, int p);
        logic [47:0] a;
        a = p ? {egress_source_address_high[47:24], egress_source_address_low[47:24]}
              : {egress_source_address_high[23:0], egress_source_address_low[23:0]};
        if (mode == 1 && i < 6) return fb[i + 6];
        if (mode == 1 && i < 12) return (i == 6) ? (fb[0] & 8'hFE) : fb[i - 6];
        if (mode == 2 && i >= 6 && i < 12) return a[8 * (11 - i) +: 8];
        return fb[i];
    endfunction : exp_byte
    // mode 0 plain, 1 address swap, 2 source address replacement
    task automatic run_frame(int mode, int n);
        int q, p, nf, off;
        logic t;
        logic [127:0] h, e;
        while (pops == taken) @(negedge sys_clk);
        taken++;
        p = ((ne_seen & queue_port_map) == 8'h00) ? 0 : ((ne_seen & ~queue_port_map) == 8'h00) ? 1 : turn;
        turn = 1 - p;
        q = exp_pick(ne_seen & (p ? queue_port_map : ~queue_port_map), round_robin_enable[p], last_q[p]);
        nf = sink.nframes;
        chk(pop_seen, 8'h01 << q);
        @(posedge sys_clk);
        for (int i = 0; i < 8; i++) if (pop_seen[i]) qcnt[i]--;
        last_q[p] = q;
        queue_nonempty <= nonempty_now();
        for (int i = 0; i < n; i++) fb[i] = 8'($urandom);
        fb[0][0] = 1'b1;
        rewrite_command <= 9'($urandom);
        receive_time_value <= $urandom;
        frame_length <= 14'(n);
        ingress_port_number <= 4'($urandom_range(0, 11));
        rule_identifier <= 6'($urandom);
        sampling_identifier <= 4'($urandom);
        {copy_to_host_action, single_hit_copy_action, drop_level, tag_kind, dei} <= 5'($urandom);
        {learning_action, service_class, pcp} <= 8'($urandom);
        queue_hit_mask <= 8'($urandom);
        vid <= 12'($urandom);
        egress_source_address_low <= 48'({$urandom, $urandom});
        egress_source_address_high <= 48'({$urandom, $urandom});
        lookup_rewrite_command <= (mode == 1) ? 4'h8 : 4'($urandom_range(0, 7));
        source_address_replace_enable <= (mode == 2); // never together with the swap
        for (int i = 0; i < n; i++) begin
            in_valid <= 1'b1;
            in_sof <= (i == 0);
            in_eof <= (i == n - 1);
            in_data <= fb[i];
            do begin
                @(negedge sys_clk);
                t = in_ready;
                if (i == 0) chk(busy, 1'b1);
                @(posedge sys_clk);
            end while (t !== 1'b1);
        end
        in_valid <= 1'b0;
        while (sink.nframes == nf) @(posedge sys_clk);
        off = header_insert_enable[p] ? 16 : 0;
        chk(sink.len, off + n);
        chk(sink.port, p);
        for (int b = 0; b < 16; b++) h[127 - 8 * b -: 8] = sink.cap[b];
        e = exp_hdr();
        if (off > 0) begin
            chk(h[127:117], e[127:117]);
            chk(h[116:85], e[116:85]);
            chk(h[84:71], e[84:71]);
            chk(h[70:43], e[70:43]);
            chk(h[42:36], e[42:36]);
            chk(h[35:31], e[35:31]);
            chk(h[30:28], e[30:28]);
            chk(h[27:17], e[27:17]);
            chk(h[16:0], e[16:0]);
        end
        for (int i = 0; i < n; i++) chk(sink.cap[off + i], exp_byte(i, mode, p));
    endtask : run_frame
    initial begin
        void'($urandom(94136));
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        // strict order on port 11 with header
        header_insert_enable <= 2'b11;
        qcnt = '{1, 0, 2, 0, 1, 0, 0, 1};
        queue_nonempty <= nonempty_now();
        run_frame(1, 12);
        while (nonempty_now() !== 8'h00) run_frame($urandom_range(0, 2), $urandom_range(13, 40));
        // round robin on port 12
        queue_port_map <= 8'hFF;
        round_robin_enable <= 2'b10;
        qcnt = '{1, 1, 0, 1, 2, 0, 1, 1};
        queue_nonempty <= nonempty_now();
        while (nonempty_now() !== 8'h00) run_frame($urandom_range(0, 2), $urandom_range(12, 40));
        // host stalls until the fifo refuses, no header on port 11
        queue_port_map <= 8'h00;
        header_insert_enable <= 2'b10;
        qcnt[3] = 1;
        queue_nonempty <= nonempty_now();
        fork
            run_frame(2, 40);
            begin
                @(posedge sys_clk);
                stall <= 1'b1;
                repeat (60) @(posedge sys_clk);
                @(negedge sys_clk);
                chk(in_ready, 1'b0);
                @(posedge sys_clk);
                stall <= 1'b0;
            end
        join
        // random mix on both ports
        for (int k = 0; k < 16; k++) begin
            queue_port_map <= 8'($urandom);
            round_robin_enable <= 2'($urandom);
            header_insert_enable <= 2'($urandom);
            qcnt[$urandom_range(0, 7)]++;
            qcnt[$urandom_range(0, 7)]++;
            queue_nonempty <= nonempty_now();
            while (nonempty_now() !== 8'h00) run_frame($urandom_range(0, 2), $urandom_range(12, 48));
        end
        @(negedge sys_clk);
        chk(busy, 1'b0);
        finish_test();
    end
endmodule : cxr_top_test
`default_nettype wire
